/* verilog/fscl_regs.vh */
// fuse and signature constants for the configuration latch
`ifndef FSCL_REGS_VH
`define FSCL_REGS_VH
`define FSCL_SIG_ADDR0      2'h0
`define FSCL_SIG_ADDR1      2'h1
`define FSCL_SIG_ADDR2      2'h2
`define FSCL_EXT_RESET      8'hf3
`define FSCL_HIGH_RESET     8'h99
`define FSCL_LOW_RESET      8'h5e
`define FSCL_EXT_UNUSED     8'hf0
`define FSCL_EXT_HWBOOT     3
`define FSCL_HIGH_DEBUG     7
`define FSCL_HIGH_SCAN      6
`define FSCL_HIGH_SERIAL    5
`define FSCL_HIGH_WDOG      4
`define FSCL_HIGH_EEPROM_PRESERVE_FUSE    3
`define FSCL_HIGH_BOOTVEC   0
`define FSCL_LOW_CLOCK_OUTPUT_FUSE      6
`define FSCL_XA_ADDR        2'h0
`define FSCL_XA_DATA        2'h1
`define FSCL_XA_CMD         2'h2
`define FSCL_CMD_ERASE      8'h80
`define FSCL_CMD_WFUSE      8'h40
`define FSCL_CMD_RSIG       8'h08
`define FSCL_CMD_RFUSE      8'h04
`define FSCL_BUSY_CYCLES    8'h10
`endif

/* verilog/fscl_config_latch.v */
// fuse storage, live configuration latch and parallel programming decode
// Function
// - fuse bits read 0 when programmed, 1 when unprogrammed.
// - extended byte: bit3 hardware boot, bits2-0 brown-out level, upper bits read 1.
// - high bit7 enables debug, bit6 enables scan port.
// - high bit5 serial programming enable; unchangeable in serial programming mode.
// - programmed high bit4 forces watchdog permanently on.
// - programmed high bit3 keeps eeprom through chip erase.
// - high bits2-1 boot size, bit0 reset vector select.
// - default clock source field selects external crystal 8 MHz.
// - default start-up field selects longest start-up delay.
// - programmed low bit6 drives system clock onto port c bit 7.
// - chip erase never changes fuse bytes.
// - fuse writes rejected while lock bit one programmed.
// - fuses latched on programming entry; changes apply at the next programming entry, and reset reloads the default fuse bytes.
// - eeprom preserve fuse acts immediately once written.
// - fuses latched at power-up in normal mode.
// - three signature bytes at 0x000-0x002, readable even when locked.
// - calibration byte is high byte of signature address 0x000.
// - every reset copies calibration byte into oscillator trim register.
// - crystal action pins set before rising crystal pulse select load.
// - write or output-enable low pulse executes last loaded command.
// - programmed debug fuse keeps clocks running in sleep.
// - action 00 address, 01 data, 10 command, 11 nothing.
// - command 0x08 reads signature and calibration bytes.
// - command 0x04 reads fuse and lock bytes.
`timescale 1ns/1ps
`include "fscl_regs.vh"
module fscl_config_latch
#(
   parameter [7:0] SIG_BYTE0 = 8'h11, // arbitrary identity value
   parameter [7:0] SIG_BYTE1 = 8'h22, // arbitrary identity value
   parameter [7:0] SIG_BYTE2 = 8'h33, // arbitrary identity value
   parameter [7:0] CAL_BYTE  = 8'h80  // factory trim value
)
(
   input  wire       clk,                  // system clock
   input  wire       reset,                // async reset, active high
   input  wire       progMode,             // parallel programming mode active
   input  wire       serialProgMode,       // serial programming mode active
   input  wire       lockBitOne,           // lock bit one, 0 = programmed
   input  wire       crystalInputPin,      // crystal input pin, pulsed high
   input  wire       crystalActionBit1,    // action select bit 1
   input  wire       crystalActionBit0,    // action select bit 0
   input  wire       writeStrobeN,         // write pulse, active low
   input  wire       outputEnableN,        // output enable, active low
   input  wire       byteSelect1,          // byte select 1
   input  wire       byteSelect2,          // byte select 2
   input  wire [7:0] dataIn,               // data bus input
   output reg  [7:0] dataOut,              // data bus output
   output reg        dataOe,               // data bus drive enable
   output reg        readyBusy,            // 1 ready, 0 busy
   output reg        eraseEeprom,          // pulse: chip erase clears eeprom
   output reg        eraseFlash,           // pulse: chip erase of flash and locks
   output reg        eepromPreserveFuse,   // immediate eeprom preserve, 0 = on
   output reg        hardwareBootFuse,     // latched, 0 = programmed
   output reg  [2:0] brownoutLevel,        // latched brown-out level
   output reg        debugEnableFuse,      // latched, 0 = programmed
   output reg        scanPortEnableFuse,   // latched, 0 = programmed
   output reg        serialProgEnableFuse, // latched, 0 = programmed
   output reg        watchdogForcedOn,     // 1 = watchdog forced on
   output reg  [1:0] bootSize,             // latched boot size field
   output reg        bootVectorSelect,     // latched, 0 = boot section vector
   output reg  [7:0] lowClockFuses,        // latched clock fuses
   output reg        clockToPortC7,        // 1 = system clock on port c bit 7
   output reg        sleepClocksRun,       // 1 = clocks kept running in sleep
   output reg  [7:0] oscillatorTrimRegister // oscillator trim
);

   reg  [7:0] extFuse_r;
   reg  [7:0] highFuse_r;
   reg  [7:0] lowFuse_r;
   reg  [7:0] extLatch_r;
   reg  [7:0] highLatch_r;
   reg  [7:0] lowLatch_r;
   reg  [7:0] cmd_r;
   reg  [7:0] addrLow_r;
   reg  [7:0] dataLatch_r;
   reg  [7:0] busyCnt_r;
   reg        progMode_r;
   reg        powerUp_r;
   reg  [2:0] xtalSync_r;
   reg  [2:0] wrSync_r;
   reg  [2:0] oeSync_r;
   reg  [2:0] pmSync_r;
   wire       xtalRise;
   wire       wrFall;
   wire       oeLow;
   wire       pmLevel;
   wire [1:0] action;
   wire [7:0] highWrite;
   wire [7:0] readByte;

   // selects the byte read by the fuse/lock and signature commands
   function [7:0] readMux;
      input [7:0] cmd;
      input [1:0] sel;
      input [7:0] addr;
      input [7:0] e;
      input [7:0] h;
      input [7:0] l;
      input       lk;
      begin
         readMux = 8'hff;
         if (cmd == `FSCL_CMD_RFUSE)
         begin
            case (sel)
               2'h0:    readMux = l;
               2'h1:    readMux = {7'h7f, lk};
               2'h2:    readMux = e;
               default: readMux = h;
            endcase
         end
         else if (cmd == `FSCL_CMD_RSIG)
         begin
            // calibration on high byte of 0x000
            if (sel[0] && addr[1:0] == `FSCL_SIG_ADDR0)
               readMux = CAL_BYTE;
            else if (addr[1:0] == `FSCL_SIG_ADDR0)
               readMux = SIG_BYTE0;
            else if (addr[1:0] == `FSCL_SIG_ADDR1)
               readMux = SIG_BYTE1;
            else if (addr[1:0] == `FSCL_SIG_ADDR2)
               readMux = SIG_BYTE2;
         end
      end
   endfunction

   // pins cross in via three flops; edges count when stages two and three differ, levels when they agree
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         xtalSync_r <= 3'h0;
         wrSync_r   <= 3'h7;
         oeSync_r   <= 3'h7;
         pmSync_r   <= 3'h0;
      end
      else
      begin
         xtalSync_r <= {xtalSync_r[1:0], crystalInputPin};
         wrSync_r   <= {wrSync_r[1:0], writeStrobeN};
         oeSync_r   <= {oeSync_r[1:0], outputEnableN};
         pmSync_r   <= {pmSync_r[1:0], progMode};
      end
   end

   assign xtalRise = xtalSync_r[1] & ~xtalSync_r[2];
   assign wrFall   = ~wrSync_r[1] & wrSync_r[2];
   assign oeLow    = ~oeSync_r[1] & ~oeSync_r[2];
   assign pmLevel  = pmSync_r[1] & pmSync_r[2];
   // action pins sampled unsynchronised on the clock edge two cycles after the crystal rise is first registered
   assign action   = {crystalActionBit1, crystalActionBit0};
   assign readByte = readMux(cmd_r, {byteSelect2, byteSelect1}, addrLow_r,
                             extFuse_r, highFuse_r, lowFuse_r, lockBitOne);
   // serial-enable bit held while in serial programming mode
   assign highWrite = serialProgMode ?
                      {dataLatch_r[7:6], highFuse_r[`FSCL_HIGH_SERIAL], dataLatch_r[4:0]} :
                      dataLatch_r;

   // loads and command execution
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         cmd_r       <= 8'h00;
         addrLow_r   <= 8'h00;
         dataLatch_r <= 8'hff;
         busyCnt_r   <= 8'h00;
         readyBusy   <= 1'b1;
         eraseEeprom <= 1'b0;
         eraseFlash  <= 1'b0;
         dataOut     <= 8'hff;
         dataOe      <= 1'b0;
      end
      else
      begin
         eraseEeprom <= 1'b0;
         eraseFlash  <= 1'b0;
         if (xtalRise && pmLevel)
         begin
            case (action)
               `FSCL_XA_ADDR: addrLow_r <= dataIn;
               `FSCL_XA_DATA: dataLatch_r <= dataIn;
               `FSCL_XA_CMD:  cmd_r <= dataIn;
               default:       cmd_r <= cmd_r;
            endcase
         end
         if (wrFall && pmLevel && readyBusy && cmd_r == `FSCL_CMD_ERASE)
         begin
            eraseFlash  <= 1'b1;
            eraseEeprom <= highFuse_r[`FSCL_HIGH_EEPROM_PRESERVE_FUSE];
         end
         if (wrFall && pmLevel && readyBusy &&
             (cmd_r == `FSCL_CMD_ERASE || cmd_r == `FSCL_CMD_WFUSE))
         begin
            busyCnt_r <= `FSCL_BUSY_CYCLES;
            readyBusy <= 1'b0;
         end
         else if (busyCnt_r != 8'h00)
         begin
            busyCnt_r <= busyCnt_r - 8'h01;
            readyBusy <= (busyCnt_r == 8'h01);
         end
         dataOe  <= oeLow && pmLevel;
         dataOut <= readByte;
      end
   end

   // non-volatile fuse bytes; chip erase never touches them
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         // default clock source 8 MHz crystal
         extFuse_r  <= `FSCL_EXT_RESET;
         highFuse_r <= `FSCL_HIGH_RESET;
         lowFuse_r  <= `FSCL_LOW_RESET;
      end
      // only the write-fuse command alters fuses
      else if (wrFall && pmLevel && readyBusy && cmd_r == `FSCL_CMD_WFUSE && lockBitOne)
      begin
         case ({byteSelect2, byteSelect1})
            2'h0:    lowFuse_r <= dataLatch_r;
            2'h1:    highFuse_r <= highWrite;
            2'h2:    extFuse_r <= dataLatch_r | `FSCL_EXT_UNUSED;
            default: extFuse_r <= extFuse_r;
         endcase
      end
   end

   // live copies and decoded outputs
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         extLatch_r  <= `FSCL_EXT_RESET;
         highLatch_r <= `FSCL_HIGH_RESET;
         lowLatch_r  <= `FSCL_LOW_RESET;
         progMode_r  <= 1'b0;
         powerUp_r   <= 1'b1;
         eepromPreserveFuse     <= 1'b1;
         hardwareBootFuse       <= 1'b1;
         brownoutLevel          <= 3'h7;
         debugEnableFuse        <= 1'b1;
         scanPortEnableFuse     <= 1'b1;
         serialProgEnableFuse   <= 1'b1;
         watchdogForcedOn       <= 1'b0;
         bootSize               <= 2'h3;
         bootVectorSelect       <= 1'b1;
         lowClockFuses          <= 8'hff;
         clockToPortC7          <= 1'b0;
         sleepClocksRun         <= 1'b0;
         oscillatorTrimRegister <= 8'h00;
      end
      else
      begin
         progMode_r <= pmLevel;
         powerUp_r  <= 1'b0;
         // trim reloaded on the first edge after each reset
         if (powerUp_r)
            oscillatorTrimRegister <= CAL_BYTE;
         // capture on programming entry and at power-up in normal mode
         if ((pmLevel && !progMode_r) || (powerUp_r && !pmLevel))
         begin
            extLatch_r  <= extFuse_r;
            highLatch_r <= highFuse_r;
            lowLatch_r  <= lowFuse_r;
         end
         // preserve fuse follows storage at once
         eepromPreserveFuse <= highFuse_r[`FSCL_HIGH_EEPROM_PRESERVE_FUSE];
         hardwareBootFuse     <= extLatch_r[`FSCL_EXT_HWBOOT];
         brownoutLevel        <= extLatch_r[2:0];
         debugEnableFuse      <= highLatch_r[`FSCL_HIGH_DEBUG];
         scanPortEnableFuse   <= highLatch_r[`FSCL_HIGH_SCAN];
         serialProgEnableFuse <= highLatch_r[`FSCL_HIGH_SERIAL];
         watchdogForcedOn     <= ~highLatch_r[`FSCL_HIGH_WDOG];
         bootSize             <= highLatch_r[2:1];
         bootVectorSelect     <= highLatch_r[`FSCL_HIGH_BOOTVEC];
         lowClockFuses        <= lowLatch_r;
         clockToPortC7        <= ~lowLatch_r[`FSCL_LOW_CLOCK_OUTPUT_FUSE];
         // debug fuse keeps clocks in sleep
         sleepClocksRun       <= ~highLatch_r[`FSCL_HIGH_DEBUG];
      end
   end

endmodule

/* testbench/fscl_config_latch_asserts.sv */
// concurrent checks on the fuse latch ports
`timescale 1ns/1ps
module fscl_config_latch_asserts
#(
   parameter [7:0] CAL_BYTE = 8'h80 // trim expected after reset
)
(
   input wire       clk,                   // clock
   input wire       reset,                 // async reset
   input wire       progMode,              // prog mode pin
   input wire       outputEnableN,         // read enable
   input wire       dataOe,                // bus drive
   input wire       readyBusy,             // 1 ready
   input wire       eraseEeprom,           // erase pulse
   input wire       eraseFlash,            // erase pulse
   input wire       eepromPreserveFuse,    // raw preserve
   input wire       debugEnableFuse,       // latched
   input wire       watchdogForcedOn,      // decoded
   input wire [7:0] lowClockFuses,         // latched
   input wire       clockToPortC7,         // decoded
   input wire       sleepClocksRun,        // decoded
   input wire [7:0] oscillatorTrimRegister // trim
);
   reg [4:0] busyCnt_r;
   reg [3:0] progCnt_r;
   // counters let busy length be asserted exactly and mark 15 or more cycles in mode
   always @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         busyCnt_r <= 5'h0;
         progCnt_r <= 4'h0;
      end
      else
      begin
         busyCnt_r <= readyBusy ? 5'h0 : busyCnt_r + 5'h1;
         progCnt_r <= !progMode ? 4'h0 : progCnt_r + {3'h0, progCnt_r != 4'hf};
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   AST_BUSY_LEN: assert property ($rose(readyBusy) |-> busyCnt_r == 5'h10)
      else $error("busy time wrong");
   AST_ERASE_EE: assert property (eraseEeprom |-> eraseFlash && eepromPreserveFuse)
      else $error("eeprom erase wrong");
   AST_ERASE_BUSY: assert property (eraseFlash |-> ##[0:1] !readyBusy)
      else $error("erase without busy");
   AST_PULSE: assert property (eraseFlash |=> !eraseFlash)
      else $error("erase pulse too long");
   AST_LATCH_HOLD: assert property (progCnt_r == 4'hf |-> $stable({watchdogForcedOn, debugEnableFuse, lowClockFuses}))
      else $error("latched config moved in mode");
   AST_SLEEP: assert property (!$past(reset) |-> sleepClocksRun == !debugEnableFuse)
      else $error("sleep clocks wrong");
   AST_CLOCK_OUTPUT_FUSE: assert property (!$past(reset) |-> clockToPortC7 == !lowClockFuses[6])
      else $error("clock output wrong");
   AST_OE_OFF: assert property (outputEnableN [*6] |-> !dataOe)
      else $error("bus driven without enable");
   AST_OE_ON: assert property ((!outputEnableN && progMode) [*5] |-> dataOe)
      else $error("bus not driven on read");
   AST_TRIM: assert property (!$past(reset) |-> oscillatorTrimRegister == CAL_BYTE)
      else $error("trim not loaded");
endmodule
bind fscl_config_latch fscl_config_latch_asserts #(.CAL_BYTE(CAL_BYTE)) i_chk (.*);

/* testbench/fscl_prog_model.sv */
// parallel programmer model driving the device pins
`timescale 1ns/1ps
module fscl_prog_model
(
   input  wire       clk,               // clock
   input  wire       readyBusy,         // 1 ready
   input  wire [7:0] dataOut,           // read data
   output reg        progMode,          // mode pin
   output reg        crystalInputPin,   // load pulse
   output reg        crystalActionBit1, // action 1
   output reg        crystalActionBit0, // action 0
   output reg        writeStrobeN,      // write pulse
   output reg        outputEnableN,     // read enable
   output reg        byteSelect1,       // select 1
   output reg        byteSelect2,       // select 2
   output reg  [7:0] dataIn             // bus to device
);
   initial
   begin
      {progMode, crystalInputPin, crystalActionBit1, crystalActionBit0} = 4'h3;
      {writeStrobeN, outputEnableN, byteSelect1, byteSelect2} = 4'hc;
      dataIn = 8'h5a;
   end
   task hold(input integer n);
      repeat (n) @(posedge clk);
   endtask
   task mode(input m);
      @(posedge clk);
      progMode <= m;
      hold(10);
   endtask
   task load(input [1:0] a, input [1:0] bs, input [7:0] d);
      @(posedge clk);
      {crystalActionBit1, crystalActionBit0} <= a;
      {byteSelect2, byteSelect1} <= bs;
      dataIn <= d;
      hold(4);
      crystalInputPin <= 1'b1;
      hold(4);
      crystalInputPin <= 1'b0;
      hold(4);
      // released bus must not keep the old value
      dataIn <= ~d;
   endtask
   task write(input [1:0] bs, output ok);
      integer i;
      reg     seen;
      @(posedge clk);
      {byteSelect2, byteSelect1} <= bs;
      writeStrobeN <= 1'b0;
      seen = 1'b0;
      ok = 1'b0;
      for (i = 0; i < 60 && !ok; i = i + 1)
      begin
         @(posedge clk);
         if (i == 4)
            writeStrobeN <= 1'b1;
         seen = seen | !readyBusy;
         ok = seen & readyBusy;
      end
   endtask
   task read(input [1:0] bs, output [7:0] v);
      @(posedge clk);
      {byteSelect2, byteSelect1} <= bs;
      outputEnableN <= 1'b0;
      hold(6);
      v = dataOut;
      outputEnableN <= 1'b1;
      hold(6);
   endtask
endmodule

/* testbench/fuse_signature_config_latch_bench.sv */
// self-checking bench for the fuse and signature latch
`timescale 1ns/1ps
`include "fscl_regs.vh"
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
   $display("mismatch %s exp %h got %h", nm, e, a); end end
module fuse_signature_config_latch_bench;
   reg        clk = 1'b0;
   reg        reset = 1'b1;
   reg        serialProgMode = 1'b0;
   reg        lockBitOne = 1'b1;
   wire       progMode, crystalInputPin, crystalActionBit1, crystalActionBit0, writeStrobeN, outputEnableN;
   wire       byteSelect1, byteSelect2, dataOe, readyBusy, eraseEeprom, eraseFlash, eepromPreserveFuse;
   wire       hardwareBootFuse, debugEnableFuse, scanPortEnableFuse, serialProgEnableFuse, watchdogForcedOn;
   wire       bootVectorSelect, clockToPortC7, sleepClocksRun;
   wire [7:0] dataIn, dataOut, lowClockFuses, oscillatorTrimRegister;
   wire [2:0] brownoutLevel;
   wire [1:0] bootSize;
   integer    n_fail = 0, n_tests = 0, nFlash = 0, nEeprom = 0, i;
   reg        ok;
   reg  [7:0] v;
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      nFlash += eraseFlash;
      nEeprom += eraseEeprom;
   end
   fscl_config_latch i_dut (.*);
   fscl_prog_model i_prog (.*);
   task wrap_up;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task cmd(input [7:0] c);
      i_prog.load(2'h2, 2'h0, c);
   endtask
   task exec(input [1:0] bs);
      i_prog.write(bs, ok);
      if (!ok)
      begin
         n_fail++;
         wrap_up;
      end
   endtask
   task rdchk(input [1:0] bs, input [7:0] e);
      i_prog.read(bs, v);
      `CHK("readback", e, v)
   endtask
   task t_defaults;
      `CHK("trim", 8'h80, oscillatorTrimRegister)
      `CHK("low", `FSCL_LOW_RESET, lowClockFuses)
      `CHK("high", 7'h41, {debugEnableFuse, scanPortEnableFuse, serialProgEnableFuse, watchdogForcedOn, bootSize, bootVectorSelect})
      `CHK("ext", 4'h3, {hardwareBootFuse, brownoutLevel})
      `CHK("preserve", 1'b1, eepromPreserveFuse)
   endtask
   task t_fuses;
      i_prog.mode(1'b1);
      cmd(`FSCL_CMD_ERASE);
      exec(2'h0);
      `CHK("eeprom erased", 1, nEeprom)
      cmd(`FSCL_CMD_WFUSE);
      i_prog.load(2'h1, 2'h0, 8'h66);
      @(posedge clk) serialProgMode <= 1'b1;
      exec(2'h1);
      `CHK("preserve now", 1'b0, eepromPreserveFuse)
      `CHK("wdog held", 1'b0, watchdogForcedOn)
      @(posedge clk) serialProgMode <= 1'b0;
      i_prog.load(2'h1, 2'h0, 8'h1e);
      exec(2'h0);
      i_prog.mode(1'b0);
      i_prog.mode(1'b1);
      `CHK("high live", 7'h2e, {debugEnableFuse, scanPortEnableFuse, serialProgEnableFuse, watchdogForcedOn, bootSize, bootVectorSelect})
      `CHK("sleep", 1'b1, sleepClocksRun)
      `CHK("clock_output_fuse", 1'b1, clockToPortC7)
      `CHK("low live", 8'h1e, lowClockFuses)
      cmd(`FSCL_CMD_RFUSE);
      rdchk(2'h3, 8'h46);
      rdchk(2'h0, 8'h1e);
      rdchk(2'h2, `FSCL_EXT_RESET);
   endtask
   task t_locked;
      @(posedge clk) lockBitOne <= 1'b0;
      cmd(`FSCL_CMD_WFUSE);
      i_prog.load(2'h1, 2'h0, 8'hff);
      exec(2'h0);
      cmd(`FSCL_CMD_ERASE);
      exec(2'h0);
      `CHK("flash erased", 2, nFlash)
      `CHK("eeprom kept", 1, nEeprom)
      cmd(`FSCL_CMD_RFUSE);
      // idle action must not replace the read command
      i_prog.load(2'h3, 2'h0, 8'h80);
      rdchk(2'h0, 8'h1e);
      rdchk(2'h3, 8'h46);
      cmd(`FSCL_CMD_RSIG);
      for (i = 0; i < 3; i++)
      begin
         i_prog.load(2'h0, 2'h0, i[7:0]);
         rdchk(2'h0, 8'h11 * (i + 1));
      end
      i_prog.load(2'h0, 2'h0, 8'h00);
      rdchk(2'h1, 8'h80);
   endtask
   task t_reset;
      i_prog.mode(1'b0);
      @(posedge clk) reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("trim again", 8'h80, oscillatorTrimRegister)
   endtask
   initial
   begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      repeat (4) @(posedge clk);
      t_defaults;
      t_fuses;
      t_locked;
      t_reset;
      wrap_up;
   end
endmodule
